// File: hdl/rif_cfg.svh
// constants for the rtc interrupt flag and rate select block
// Functional notes
// RULE_01: summary flag is any flag with enable
// RULE_02: interrupt pin low while summary flag set
// RULE_03: status read or reset clears all flags
// RULE_04: periodic flag set on tap edge always; code sets it only in the osc_run state
// RULE_05: alarm flag set on alarm match
// RULE_06: update flag set after each update
// RULE_07: status low nibble reads zero, unwritable
// RULE_08: battery bit read-only, reset leaves it
// RULE_09: battery register low bits read zero
// RULE_10: 114 ram bytes always host accessible
// RULE_11: power fail forces external sram deselected
// RULE_12: enabling a set flag asserts pin immediately
// RULE_13: host reads status before first enabling
// RULE_14: status stable during read, events deferred
// RULE_15: one tap selector feeds periodic and square
// RULE_16: oscillator control 010 run, 11x hold
// RULE_17: codes 0000 off, 0001/0010 low rates
// RULE_18: codes 0011 up double each period
// RULE_19: enables and square enable cleared by reset
// RULE_20: setting time-set inhibit clears update enable
// RULE_21: square pin low when square output disabled
// RULE_22: rate select bits survive reset
// RULE_23: read clear acts at end of strobe
// RULE_24: flags are sticky, set wins over clear
`ifndef RIF_CFG_SVH
`define RIF_CFG_SVH
`define RIF_OFF_CTRL_A 7'h0A
`define RIF_OFF_CTRL_B 7'h0B
`define RIF_OFF_STATUS 7'h0C
`define RIF_OFF_BATT 7'h0D
`define RIF_OFF_RAM 7'h0E
`define RIF_B_SET 7
`define RIF_B_SQUARE_OUT_EN 3
`define RIF_B_DM 2
`define RIF_B_HR24 1
`define RIF_B_DSE 0
`define RIF_EN_RESET 3'h0
`define RIF_FLAG_RESET 3'h0
`define RIF_OSC_RUN_CODE 3'h2
`define RIF_TAP_FIRST 4'h3
`define RIF_TAP_ALIAS 4'h7
`endif

// File: hdl/rif_pkg.sv
// types for the rtc interrupt flag and rate select block
package rif_pkg;
   typedef enum logic [2:0] {
      osc_stop = 3'b001,
      osc_hold = 3'b010,
      osc_run = 3'b100
   } rif_osc_t;
endpackage : rif_pkg

// File: hdl/rif_core.sv
// rtc interrupt flags, rate select, control and status registers, user ram
`timescale 1ns/1ps
`include "rif_cfg.svh"
module rif_core #(
   parameter int RAM_BYTES = 114,
   parameter int DIV_STAGES = 15
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] ad_i,
   output logic [7:0] ad_o,
   output logic ad_oe,
   input wire logic as_strobe,
   input wire logic ds_strobe,
   input wire logic rw_read,
   input wire logic cs_n,
   input wire logic osc_tick,
   input wire logic alarm_match,
   input wire logic update_done,
   input wire logic update_in_progress,
   input wire logic battery_valid,
   input wire logic power_fail,
   input wire logic ext_ce_in_n,
   output logic irq_n,
   output logic sqw,
   output logic ext_ce_n,
   output logic osc_enable
);
   // tap mux and register map are laid out for these sizes only
   if (RAM_BYTES != 114 || DIV_STAGES != 15) begin : g_size_check
      $error("rif_core: map needs 114 ram bytes and 15 divider stages");
   end

   function automatic rif_pkg::rif_osc_t osc_decode(input logic [2:0] code);
      rif_pkg::rif_osc_t st;
      st = rif_pkg::osc_stop;
      if (code == `RIF_OSC_RUN_CODE) begin
         st = rif_pkg::osc_run;
      end else if (code[2:1] == 2'h3) begin
         st = rif_pkg::osc_hold;
      end
      return st;
   endfunction : osc_decode

   // rate code to divider stage; codes 1 and 2 alias codes 8 and 9
   function automatic logic [3:0] tap_index(input logic [3:0] rs);
      logic [3:0] idx;
      idx = rs - 4'h2;
      if (rs < `RIF_TAP_FIRST) begin
         idx = rs + 4'h5;
      end
      return idx;
   endfunction : tap_index

   logic [6:0] addr_r;
   logic [7:0] wdat_r;
   logic rd_q_r;
   logic wr_q_r;
   logic [7:0] ad_o_r;
   logic ad_oe_r;
   logic [2:0] osc_ctrl_r;
   logic [3:0] rate_sel_r;
   logic set_inhibit_r;
   logic [2:0] irq_en_r;
   logic square_out_en_r;
   logic dm_r;
   logic hr24_r;
   logic dse_r;
   logic [2:0] flag_r;
   logic [2:0] pend_r;
   rif_pkg::rif_osc_t osc_state_r;
   logic [DIV_STAGES-1:0] div_r;
   logic tap_q_r;
   logic irq_n_r;
   logic sqw_r;
   logic ext_ce_n_r;
   logic osc_en_r;
   logic [7:0] ram_r [RAM_BYTES];

   logic rd_act;
   logic wr_act;
   logic rd_start;
   logic rd_end;
   logic wr_end;
   logic stat_sel;
   logic tap;
   logic tap_rise;
   logic tap_live;
   logic [2:0] ev;
   logic interrupt_summary_flag;
   logic [7:0] rd_mux;
   logic [6:0] ram_idx;

   assign rd_act = !cs_n && ds_strobe && rw_read;
   assign wr_act = !cs_n && ds_strobe && !rw_read;
   assign rd_start = rd_act && !rd_q_r;
   assign rd_end = rd_q_r && !rd_act;
   assign wr_end = wr_q_r && !wr_act;
   assign stat_sel = addr_r == `RIF_OFF_STATUS;
   assign ram_idx = addr_r - `RIF_OFF_RAM;
   assign tap = (rate_sel_r != 4'h0) && div_r[tap_index(rate_sel_r)]; // RULE_15 RULE_17 RULE_18
   assign tap_rise = tap && !tap_q_r;
   // edges count only while the chain runs, so an unwritten rate code stays harmless
   assign tap_live = tap_rise && osc_state_r == rif_pkg::osc_run;
   // bit order {periodic, alarm, update}
   assign ev = {tap_live, alarm_match, update_done}; // RULE_04 RULE_05 RULE_06
   assign interrupt_summary_flag = |(flag_r & irq_en_r); // RULE_01 RULE_12

   // bus strobes; address latched while the address strobe is high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 7'h00;
         rd_q_r <= 1'b0;
         wr_q_r <= 1'b0;
         wdat_r <= 8'h00;
      end else begin
         if (as_strobe) begin
            addr_r <= ad_i[6:0];
         end
         rd_q_r <= rd_act;
         wr_q_r <= wr_act;
         if (wr_act) begin
            wdat_r <= ad_i;
         end
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (addr_r == `RIF_OFF_CTRL_A) begin
         rd_mux = {update_in_progress, osc_ctrl_r, rate_sel_r};
      end else if (addr_r == `RIF_OFF_CTRL_B) begin
         rd_mux = {set_inhibit_r, irq_en_r, square_out_en_r, dm_r, hr24_r, dse_r};
      end else if (stat_sel) begin
         rd_mux = {interrupt_summary_flag, flag_r, 4'h0}; // RULE_07
      end else if (addr_r == `RIF_OFF_BATT) begin
         rd_mux = {battery_valid, 7'h00}; // RULE_08 RULE_09
      end else if (addr_r >= `RIF_OFF_RAM) begin
         rd_mux = ram_r[ram_idx]; // RULE_10
      end
   end

   // data captured once at strobe start so the host sees a frozen value
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ad_o_r <= 8'h00;
         ad_oe_r <= 1'b0;
      end else begin
         ad_oe_r <= rd_act;
         if (rd_start) begin
            ad_o_r <= rd_mux; // RULE_14
         end
      end
   end

   // no reset: these survive the reset pin
   always_ff @(posedge mclk) begin
      if (wr_end && addr_r == `RIF_OFF_CTRL_A) begin
         osc_ctrl_r <= wdat_r[6:4]; // RULE_16
         rate_sel_r <= wdat_r[3:0]; // RULE_22
      end
      if (wr_end && addr_r == `RIF_OFF_CTRL_B) begin
         set_inhibit_r <= wdat_r[`RIF_B_SET];
         dm_r <= wdat_r[`RIF_B_DM];
         hr24_r <= wdat_r[`RIF_B_HR24];
         dse_r <= wdat_r[`RIF_B_DSE];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= `RIF_EN_RESET; // RULE_19
         square_out_en_r <= 1'b0; // RULE_19
      end else if (wr_end && addr_r == `RIF_OFF_CTRL_B) begin
         irq_en_r <= {wdat_r[6:5], wdat_r[4] && !wdat_r[`RIF_B_SET]}; // RULE_20
         square_out_en_r <= wdat_r[`RIF_B_SQUARE_OUT_EN];
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_end && addr_r >= `RIF_OFF_RAM) begin
         ram_r[ram_idx] <= wdat_r; // RULE_10
      end
   end

   // per-flag sticky latch with deferral across a status read
   for (genvar g = 0; g < 3; g++) begin : g_flag
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            flag_r[g] <= 1'b0; // RULE_03
            pend_r[g] <= 1'b0;
         end else if (stat_sel && rd_end) begin
            flag_r[g] <= pend_r[g] || ev[g]; // RULE_03 RULE_23 RULE_24
            pend_r[g] <= 1'b0;
         end else if (stat_sel && rd_q_r) begin
            pend_r[g] <= pend_r[g] || ev[g]; // RULE_14
         end else begin
            flag_r[g] <= flag_r[g] || ev[g]; // RULE_24
         end
      end
   end

   // divider runs from the 32.768 kHz tick, held at zero in hold state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_state_r <= rif_pkg::osc_stop;
         div_r <= '0;
         tap_q_r <= 1'b0;
      end else begin
         osc_state_r <= osc_decode(osc_ctrl_r); // RULE_16
         tap_q_r <= tap;
         unique case (osc_state_r)
            rif_pkg::osc_run: begin
               if (osc_tick) begin
                  div_r <= div_r + 1'b1;
               end
            end
            rif_pkg::osc_hold: begin
               div_r <= '0;
            end
            rif_pkg::osc_stop: begin
               div_r <= div_r;
            end
            default: begin
               div_r <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_n_r <= 1'b1;
         sqw_r <= 1'b0;
         ext_ce_n_r <= 1'b1;
         osc_en_r <= 1'b0;
      end else begin
         irq_n_r <= !interrupt_summary_flag; // RULE_02
         sqw_r <= square_out_en_r && tap; // RULE_21
         ext_ce_n_r <= ext_ce_in_n || power_fail; // RULE_11
         osc_en_r <= osc_state_r != rif_pkg::osc_stop;
      end
   end

   assign ad_o = ad_o_r;
   assign ad_oe = ad_oe_r;
   assign irq_n = irq_n_r;
   assign sqw = sqw_r;
   assign ext_ce_n = ext_ce_n_r;
   assign osc_enable = osc_en_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_irq_pin_follow: assert property ( // RULE_02
      interrupt_summary_flag |=> !irq_n) else $error("irq pin not asserted");
   a_irq_pin_idle: assert property ( // RULE_01
      !interrupt_summary_flag |=> irq_n) else $error("irq pin asserted without cause");
   a_status_clear: assert property ( // RULE_03
      stat_sel && rd_end && ev == 3'h0 && pend_r == 3'h0 |=> flag_r == 3'h0)
      else $error("status read did not clear flags");
   a_status_stable: assert property ( // RULE_14
      stat_sel && rd_act && rd_q_r |=> $stable(ad_o_r) && $stable(flag_r))
      else $error("status changed during read");
   a_status_low_zero: assert property ( // RULE_07
      stat_sel && rd_q_r |=> ad_o_r[3:0] == 4'h0) else $error("status low bits nonzero");
   a_batt_low_zero: assert property ( // RULE_09
      addr_r == `RIF_OFF_BATT && rd_q_r |=> ad_o_r[6:0] == 7'h00)
      else $error("battery low bits nonzero");
   a_sram_block: assert property ( // RULE_11
      power_fail |=> ext_ce_n) else $error("sram not blocked on power fail");
   a_sqw_off_low: assert property ( // RULE_21
      !square_out_en_r |=> !sqw) else $error("square pin active while disabled");
   a_periodic_set: assert property ( // RULE_04
      tap_live && !(stat_sel && (rd_q_r || rd_end)) |=> flag_r[2])
      else $error("periodic flag missed");
   a_uie_set_clear: assert property ( // RULE_20
      wr_end && addr_r == `RIF_OFF_CTRL_B && wdat_r[`RIF_B_SET] |=> !irq_en_r[0])
      else $error("update enable not cleared by set bit");
   a_alarm_set: assert property ( // RULE_05
      alarm_match && !(stat_sel && rd_q_r)
      |=> flag_r[1])
      else $error("alarm flag missed");
   a_update_set: assert property ( // RULE_06
      update_done && !(stat_sel && rd_q_r)
      |=> flag_r[0])
      else $error("update flag missed");
   a_event_held: assert property ( // RULE_14
      stat_sel && rd_act && rd_q_r && ev != 3'h0
      |=> (pend_r & $past(ev)) == $past(ev))
      else $error("event during read not held");
   a_read_end_load: assert property ( // RULE_23
      stat_sel && rd_end
      |=> flag_r == $past(pend_r | ev) && pend_r == 3'h0)
      else $error("flags not reloaded at read end");
   a_flag_sticky: assert property ( // RULE_24
      !(stat_sel && rd_end)
      |=> (flag_r & $past(flag_r)) == $past(flag_r))
      else $error("flag dropped without status read");
   a_enable_late: assert property ( // RULE_12
      (irq_en_r & ~$past(irq_en_r) & flag_r) != 3'h0
      |=> !irq_n)
      else $error("late enable did not assert irq pin");
   a_irq_release: assert property ( // RULE_03
      stat_sel && rd_end && pend_r == 3'h0 && ev == 3'h0
      |=> ##1 irq_n)
      else $error("irq pin held after status read");
   a_osc_stop_off: assert property ( // RULE_16
      osc_state_r == rif_pkg::osc_stop
      |=> !osc_enable)
      else $error("oscillator enabled in stop state");
   a_osc_hold_zero: assert property ( // RULE_16
      osc_state_r == rif_pkg::osc_hold
      |=> div_r == '0)
      else $error("divider not held in hold state");
   a_osc_run_count: assert property ( // RULE_16
      osc_state_r == rif_pkg::osc_run && osc_tick
      |=> div_r == $past(div_r) + 1'b1)
      else $error("divider did not advance in run state");
   a_rate_off_quiet: assert property ( // RULE_17
      rate_sel_r == 4'h0
      |=> !sqw && !tap_q_r)
      else $error("tap active with rate code zero");
   a_rate_alias: assert property ( // RULE_17
      rate_sel_r == 4'h1
      |-> tap == div_r[6])
      else $error("rate code one on wrong stage");
   a_batt_bit: assert property ( // RULE_08
      addr_r == `RIF_OFF_BATT && rd_start
      |=> ad_o_r[7] == $past(battery_valid))
      else $error("battery bit not returned");
   a_read_flags: assert property ( // RULE_14
      stat_sel && rd_start
      |=> ad_o_r[6:4] == $past(flag_r))
      else $error("status read lost flags");
   a_drive_follow: assert property ( // RULE_14
      rd_act
      |=> ad_oe)
      else $error("bus not driven during read");
   a_drive_release: assert property ( // RULE_14
      !rd_act
      |=> !ad_oe)
      else $error("bus driven outside read");

   c_status_read: cover property (stat_sel && rd_end && flag_r != 3'h0);
   c_event_during_read: cover property (stat_sel && rd_q_r && rd_act && ev != 3'h0);
   c_periodic_irq: cover property (flag_r[2] && irq_en_r[2] ##1 !irq_n);
   c_square_toggle: cover property (sqw ##[1:300] !sqw);
   c_late_enable: cover property ((irq_en_r & ~$past(irq_en_r) & flag_r) != 3'h0);
endmodule : rif_core

// File: test/rif_host.sv
// host processor model driving the multiplexed address/data bus
`timescale 1ns/1ps
module rif_host (
   input wire logic mclk,
   input wire logic [7:0] ad_o,
   input wire logic ad_oe,
   output logic [7:0] ad_i,
   output logic as_strobe,
   output logic ds_strobe,
   output logic rw_read,
   output logic cs_n
);
   initial begin
      ad_i = 8'h00;
      as_strobe = 1'b0;
      ds_strobe = 1'b0;
      rw_read = 1'b1;
      cs_n = 1'b1;
   end

   // one byte access: address phase, then data strobe held until answer
   task automatic acc(input logic [6:0] a, input logic wr, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      n = 0;
      q = 8'h00;
      @(posedge mclk);
      as_strobe <= 1'b1;
      ad_i <= {1'b0, a};
      @(posedge mclk);
      as_strobe <= 1'b0;
      ds_strobe <= 1'b1;
      rw_read <= !wr;
      cs_n <= 1'b0;
      // on a read the host drives the inverted address, so no stale address shows
      ad_i <= wr ? d : ~{1'b0, a};
      repeat (2) @(posedge mclk);
      while (!wr && ad_oe !== 1'b1 && n < 8) begin
         @(posedge mclk);
         n++;
      end
      // without the drive enable the byte comes back inverted, so a check trips
      q = ad_o ^ {8{ad_oe !== 1'b1}};
      ds_strobe <= 1'b0;
      cs_n <= 1'b1;
      ad_i <= ~ad_i;
      repeat (2) @(posedge mclk);
   endtask : acc
endmodule : rif_host

// File: test/tb_top.sv
// self-checking bench for the rtc interrupt flag and rate select block
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic osc_tick = 1'b0;
   logic alarm_match = 1'b0;
   logic update_done = 1'b0;
   logic update_in_progress = 1'b0;
   logic battery_valid = 1'b1;
   logic power_fail = 1'b0;
   logic ext_ce_in_n = 1'b1;
   logic [7:0] ad_i;
   logic [7:0] ad_o;
   logic as_strobe, ds_strobe, rw_read, cs_n, ad_oe, irq_n, sqw, ext_ce_n, osc_enable;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;

   always #25 mclk = ~mclk;
   // one oscillator period every two clocks keeps rates easy to reckon
   always @(posedge mclk) osc_tick <= ~osc_tick;

   rif_core uut (.mclk(mclk), .rst_n(rst_n), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe),
      .as_strobe(as_strobe), .ds_strobe(ds_strobe), .rw_read(rw_read), .cs_n(cs_n),
      .osc_tick(osc_tick), .alarm_match(alarm_match), .update_done(update_done),
      .update_in_progress(update_in_progress), .battery_valid(battery_valid),
      .power_fail(power_fail), .ext_ce_in_n(ext_ce_in_n), .irq_n(irq_n), .sqw(sqw),
      .ext_ce_n(ext_ce_n), .osc_enable(osc_enable));

   rif_host host (.mclk(mclk), .ad_o(ad_o), .ad_oe(ad_oe), .ad_i(ad_i),
      .as_strobe(as_strobe), .ds_strobe(ds_strobe), .rw_read(rw_read), .cs_n(cs_n));

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         test_done();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.acc(a, 1'b1, d, q);
   endtask : wr

   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      host.acc(a, 1'b0, 8'h00, q);
      chk({8'h00, q}, {8'h00, e});
   endtask : rc

   task automatic ev(input logic am, input logic ud);
      @(posedge mclk);
      alarm_match <= am;
      update_done <= ud;
      @(posedge mclk);
      alarm_match <= 1'b0;
      update_done <= 1'b0;
   endtask : ev

   // period of sqw in clocks, between its second and third rise
   task automatic per(input logic [7:0] a, input int e);
      int r;
      int t0;
      int p;
      logic prv;
      r = 0;
      t0 = 0;
      p = 0;
      prv = 1'b1;
      wr(7'h0A, a);
      for (int n = 0; n < 3000 && r < 3; n++) begin
         @(posedge mclk);
         if (sqw === 1'b1 && prv === 1'b0) begin
            r++;
            if (r == 2) t0 = n;
            if (r == 3) p = n - t0;
         end
         prv = sqw;
      end
      chk(p[15:0], e[15:0]);
   endtask : per

   initial begin
      repeat (5) @(posedge mclk);
      chk({13'h0, irq_n, sqw, ext_ce_n}, 16'h0005);
      rst_n <= 1'b1;
      wr(7'h0A, 8'h20);
      wr(7'h0B, 8'h00);
      rc(7'h0C, 8'h00);
      rc(7'h0D, 8'h80);
      wr(7'h0D, 8'hFF);
      battery_valid <= 1'b0;
      rc(7'h0D, 8'h00);
      battery_valid <= 1'b1;
      ev(1'b1, 1'b0);
      rc(7'h0C, 8'h20);
      rc(7'h0C, 8'h00);
      wr(7'h0C, 8'hFF);
      rc(7'h0C, 8'h00);
      ev(1'b0, 1'b1);
      rc(7'h0C, 8'h10);
      ev(1'b1, 1'b0);
      repeat (3) @(posedge mclk);
      chk({15'h0, irq_n}, 16'h0001);
      wr(7'h0B, 8'h20);
      repeat (3) @(posedge mclk);
      chk({15'h0, irq_n}, 16'h0000);
      rc(7'h0C, 8'hA0);
      repeat (3) @(posedge mclk);
      chk({15'h0, irq_n}, 16'h0001);
      fork
         rc(7'h0C, 8'h00);
         begin
            repeat (2) @(posedge mclk);
            ev(1'b0, 1'b1);
         end
      join
      rc(7'h0C, 8'h10);
      wr(7'h0B, 8'h90);
      rc(7'h0B, 8'h80);
      update_in_progress <= 1'b1;
      wr(7'h0E, 8'h5A);
      wr(7'h7F, 8'hA5);
      rc(7'h0E, 8'h5A);
      rc(7'h7F, 8'hA5);
      rc(7'h05, 8'h00);
      update_in_progress <= 1'b0;
      // square enable on until register B is written with 00, periodic enable off throughout
      wr(7'h0B, 8'h08);
      per(8'h20, 0);
      per(8'h21, 256);
      per(8'h22, 512);
      per(8'h23, 8);
      per(8'h24, 16);
      per(8'h25, 32);
      per(8'h26, 64);
      rc(7'h0C, 8'h40);
      per(8'h63, 0);
      chk({15'h0, osc_enable}, 16'h0001);
      wr(7'h0A, 8'h03);
      repeat (2) @(posedge mclk);
      chk({15'h0, osc_enable}, 16'h0000);
      wr(7'h0B, 8'h00);
      per(8'h23, 0);
      ext_ce_in_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({15'h0, ext_ce_n}, 16'h0000);
      power_fail <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({15'h0, ext_ce_n}, 16'h0001);
      power_fail <= 1'b0;
      wr(7'h0A, 8'h25);
      wr(7'h0B, 8'h78);
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rc(7'h0A, 8'h25);
      rc(7'h0B, 8'h00);
      test_done();
   end
endmodule : tb_top
